// ===== hw/mfc_channel_select.sv
// Billed channel choice, miswire alarm and missing-neutral detection with an
// AHB-Lite register slave and one level interrupt.
// Assumes magnitudes and zero crossings arrive from same-clock front end logic.
//
// What this block does
// - inactive input above active by over 1/16 of it: alarm, bill that input
// - a channel swap only takes effect after about three seconds
// - swap back to phase only when phase beats neutral by over 1/16 of phase
// - alarm drops once phase is within 1/16 of neutral, billing stays neutral
// - phase input is the billed channel after reset
// - enter missing-neutral when voltage peak under 9% or no zero crossings
// - leave missing-neutral only with peak above 9% and crossings seen again
// - alarm stays high throughout missing-neutral mode
// - missing-neutral billing uses current times trim level instead of voltage
// - trim scales the rate linearly, zero gives zero, double gives double
// - zero crossing window suits line frequencies from 45 to 55 Hz
// - missing-neutral pulses follow ampere-hours on the same outputs
// - full-scale ac in the 2048 mode gives about 5.5 kHz pulses
// - on phase, neutral under 15/16 of phase raises alarm without swap
// - no imbalance detection while both currents are under 0.3% scale
`include "mfc_map.svh"

module mfc_channel_select #(
    parameter logic [31:0] SWAP_CYCLES = 32'(`MFC_SWAP_DELAY_MS * `MFC_CLK_KHZ),
    parameter logic [31:0] ZC_CYCLES = 32'(`MFC_ZC_WINDOW_US * `MFC_CLK_MHZ),
    parameter logic [55:0] CF_BASE =
        56'((64'd125_000_000 << 32) / (64'd2 * `MFC_CF_FULL_HZ))
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire mfc_pkg::mfc_ahb_in_t ahb_i,
    output mfc_pkg::mfc_ahb_out_t ahb_o,
    // front end measurements
    input wire logic mag_valid,
    input wire mfc_pkg::mfc_meas_t meas_i,
    input wire logic zero_cross,
    // strap pins
    input wire mfc_pkg::mfc_pins_t pins_i,
    // meter outputs
    output logic miswire_alarm,
    output logic billed_is_neutral,
    output logic missing_neutral,
    output logic calibration_pulse_out,
    output logic [31:0] billed_power,
    output logic irq
);
    import mfc_pkg::*;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic over_by(input logic [15:0] big, input logic [15:0] lesser);
        logic [15:0] diff;
        diff = big - lesser;
        return (big > lesser) && (diff > (big >> `MFC_IMBAL_SHIFT));
    endfunction

    mfc_state_t s_q;
    mfc_state_t s_d;

    logic over_pn;
    logic over_np;
    logic light;
    logic zc_lost;
    logic peak_low;
    logic peak_high;
    logic want_c;
    logic imbal_c;
    logic mn_c;
    logic [15:0] billed_mag;
    logic [15:0] volt_term;
    logic [55:0] cf_thr;
    logic [55:0] cf_sum;
    logic addr_phase;
    logic [3:0] events;
    logic [3:0] clr;

    // ************************************************************
    // detection terms
    // ************************************************************
    assign over_pn = over_by(s_q.meas.phase_current_input, s_q.meas.neutral_current_input);
    assign over_np = over_by(s_q.meas.neutral_current_input, s_q.meas.phase_current_input);
    assign light = (s_q.meas.phase_current_input < `MFC_LIGHT_LOAD) &&
                   (s_q.meas.neutral_current_input < `MFC_LIGHT_LOAD);
    // window is two periods at the slowest line, so 45..55 Hz never trips
    assign zc_lost = (s_q.zc_cnt == ZC_CYCLES);
    assign peak_low = s_q.meas.line_voltage_peak < `MFC_MN_PEAK;
    assign peak_high = s_q.meas.line_voltage_peak > `MFC_MN_PEAK;

    // imbalance both ways, threshold of the larger input
    assign imbal_c = s_q.det_en && !light && (over_pn || over_np);
    // swap toward the input that beats the billed one
    assign want_c = s_q.det_en && !light && (s_q.ch_neutral ? over_pn : over_np);

    // exactly equal peak keeps the present mode
    always_comb begin
        mn_c = s_q.mn;
        if (!s_q.mn && (peak_low || zc_lost)) begin
            mn_c = 1'b1;
        end else if (s_q.mn && peak_high && !zc_lost) begin
            mn_c = 1'b0;
        end
    end

    // trim code stands in for the voltage peak code
    assign billed_mag = s_q.ch_neutral ? s_q.meas.neutral_current_input :
                                         s_q.meas.phase_current_input;
    assign volt_term = s_q.mn ? s_q.meas.one_wire_gain_trim : s_q.meas.line_voltage_peak;

    // full-scale ac in the 2048 mode lands near the documented rate
    always_comb begin
        if (!s_q.pins_s2.pulse_scale_select && s_q.pins_s2.rate_select_bit1 &&
            s_q.pins_s2.rate_select_bit0) begin
            cf_thr = CF_BASE;
        end else if (s_q.pins_s2.pulse_scale_select) begin
            cf_thr = CF_BASE << `MFC_CF_SHIFT_SCF1;
        end else begin
            cf_thr = CF_BASE << `MFC_CF_SHIFT_SCF0;
        end
    end
    assign cf_sum = s_q.cf_acc + {24'h000000, s_q.power};

    assign addr_phase = ahb_i.hsel && ahb_i.hready && ahb_i.htrans[1];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        clr = 4'h0;
        events = 4'h0;

        // strap pins cross in from outside the clock domain
        s_d.pins_s1 = pins_i;
        s_d.pins_s2 = s_q.pins_s1;

        if (mag_valid) begin
            s_d.meas = meas_i;
        end

        // zero crossing watchdog, saturates at the window
        if (zero_cross) begin
            s_d.zc_cnt = 32'h00000000;
        end else if (!zc_lost) begin
            s_d.zc_cnt = s_q.zc_cnt + 32'h00000001;
        end

        s_d.imbal = imbal_c;
        s_d.mn = mn_c;
        s_d.want = want_c;

        // condition must hold the whole delay, any break restarts it
        if (!s_q.want) begin
            s_d.swap_cnt = 32'h00000000;
        end else if (s_q.swap_cnt == SWAP_CYCLES - 32'h00000001) begin
            s_d.swap_cnt = 32'h00000000;
            s_d.ch_neutral = !s_q.ch_neutral;
        end else begin
            s_d.swap_cnt = s_q.swap_cnt + 32'h00000001;
        end

        // alarm from the next imbalance and mode values
        s_d.alarm = imbal_c || mn_c;

        // billed quantity for the pulse accumulator
        s_d.power = 32'(billed_mag * volt_term);

        // one clock pulse per threshold of accumulated quantity
        if (cf_sum >= cf_thr) begin
            s_d.cf_acc = cf_sum - cf_thr;
            s_d.cf_pulse = 1'b1;
        end else begin
            s_d.cf_acc = cf_sum;
            s_d.cf_pulse = 1'b0;
        end

        events[`MFC_EV_ALARM] = s_d.alarm && !s_q.alarm;
        events[`MFC_EV_SWAP] = s_d.ch_neutral != s_q.ch_neutral;
        events[`MFC_EV_MN_ENTER] = mn_c && !s_q.mn;
        events[`MFC_EV_MN_LEAVE] = !mn_c && s_q.mn;

        // ************************************************************
        // bus slave: writes zero wait, reads one wait state
        // ************************************************************
        // reads wait a cycle so a write just before is already visible
        s_d.dp_wr = 1'b0;
        if (s_q.dp_wr) begin
            unique case (s_q.dp_addr)
                `MFC_OFF_STATUS: clr = ahb_i.hwdata[3:0];
                `MFC_OFF_MASK: s_d.mask = ahb_i.hwdata[3:0];
                `MFC_OFF_CTRL: s_d.det_en = ahb_i.hwdata[`MFC_CTRL_DET_EN];
                default: clr = 4'h0;
            endcase
        end

        // set beats clear on the same edge
        s_d.status = (s_q.status & ~clr) | events;
        s_d.irq = |(s_d.status & s_d.mask);

        if (s_q.rd_pend) begin
            s_d.rd_pend = 1'b0;
            s_d.ahb.hreadyout = 1'b1;
            unique case (s_q.dp_addr)
                `MFC_OFF_STATUS: s_d.ahb.hrdata = {28'h0000000, s_q.status};
                `MFC_OFF_MASK: s_d.ahb.hrdata = {28'h0000000, s_q.mask};
                `MFC_OFF_STATE: s_d.ahb.hrdata = {27'h0, zc_lost, s_q.imbal,
                                                  s_q.mn, s_q.ch_neutral, s_q.alarm};
                `MFC_OFF_CTRL: s_d.ahb.hrdata = {31'h0, s_q.det_en};
                default: s_d.ahb.hrdata = 32'h00000000;
            endcase
        end else if (addr_phase) begin
            // size is not checked: only whole word transfers are expected
            s_d.dp_addr = ahb_i.haddr[11:0];
            if (ahb_i.hwrite) begin
                s_d.dp_wr = 1'b1;
            end else begin
                s_d.rd_pend = 1'b1;
                s_d.ahb.hreadyout = 1'b0;
            end
        end
        s_d.ahb.hresp = 1'b0;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.mask <= `MFC_RST_MASK;
            s_q.det_en <= `MFC_RST_CTRL;
            s_q.ahb.hreadyout <= 1'b1;
            s_q.ch_neutral <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ahb_o = s_q.ahb;
    assign miswire_alarm = s_q.alarm;
    assign billed_is_neutral = s_q.ch_neutral;
    assign missing_neutral = s_q.mn;
    assign calibration_pulse_out = s_q.cf_pulse;
    assign billed_power = s_q.power;
    assign irq = s_q.irq;

    // ************************************************************
    // checks
    // ************************************************************
    a_power_up_phase: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> !s_q.ch_neutral)
        else $error("phase not billed after reset");

    a_swap_after_delay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ch_neutral != $past(s_q.ch_neutral)) |->
            ($past(s_q.swap_cnt) == SWAP_CYCLES - 32'h00000001) && $past(s_q.want))
        else $error("channel swapped without full delay");

    a_swap_to_neutral: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(s_q.ch_neutral) |-> $past(over_np, 2) && $past(s_q.alarm))
        else $error("swap to neutral without imbalance");

    a_swap_to_phase: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(s_q.ch_neutral) |-> $past(over_pn, 2))
        else $error("swap back to phase without margin");

    a_alarm_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_q.ch_neutral && !over_pn && !over_np && !mn_c) |=> !s_q.alarm)
        else $error("alarm held with inputs in band");

    a_phase_only_alarm: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!s_q.ch_neutral && over_pn && !light && s_q.det_en) |=>
            s_q.alarm && !s_q.want)
        else $error("low neutral not flagged or swapped");

    a_light_quiet: assert property (
        @(posedge hclk) disable iff (!hresetn)
        light |=> !s_q.imbal && !s_q.want)
        else $error("imbalance seen at light load");

    a_mn_enter: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (peak_low || zc_lost) |=> s_q.mn)
        else $error("missing neutral not entered");

    a_mn_leave: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(s_q.mn) |-> $past(peak_high) && !$past(zc_lost))
        else $error("missing neutral left too early");

    a_mn_alarm: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.mn |-> s_q.alarm)
        else $error("alarm low in missing neutral");

    a_mn_trim: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s_q.mn |=>
            s_q.power == 32'($past(billed_mag) * $past(s_q.meas.one_wire_gain_trim)))
        else $error("trim not used in missing neutral");

    a_read_wait: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !ahb_i.hwrite && !s_q.rd_pend) |=>
            !s_q.ahb.hreadyout ##1 s_q.ahb.hreadyout)
        else $error("read wait state wrong");

endmodule

// ===== hw/mfc_map.svh
// Register offsets, field positions, reset values and timing figures for the
// meter fault and channel select block.
// Assumes 16-bit unsigned magnitude codes where 16'hFFFF is analog full scale.
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH

// ************************************************************
// register offsets (byte addresses, one word each)
// ************************************************************
`define MFC_OFF_STATUS 12'h000
`define MFC_OFF_MASK 12'h004
`define MFC_OFF_STATE 12'h008
`define MFC_OFF_CTRL 12'h00C

// ************************************************************
// field positions
// ************************************************************
`define MFC_EV_ALARM 0
`define MFC_EV_SWAP 1
`define MFC_EV_MN_ENTER 2
`define MFC_EV_MN_LEAVE 3
`define MFC_ST_ALARM 0
`define MFC_ST_NEUTRAL 1
`define MFC_ST_MN 2
`define MFC_ST_IMBAL 3
`define MFC_ST_ZC_LOST 4
`define MFC_CTRL_DET_EN 0

// ************************************************************
// reset values and thresholds
// ************************************************************
`define MFC_RST_MASK 4'h0
`define MFC_RST_CTRL 1'h1
`define MFC_LIGHT_LOAD 16'h00C4
`define MFC_MN_PEAK 16'h170A
`define MFC_IMBAL_SHIFT 4

// ************************************************************
// timing
// ************************************************************
`define MFC_CLK_MHZ 125
`define MFC_CLK_KHZ 125000
`define MFC_SWAP_DELAY_MS 3000
`define MFC_ZC_WINDOW_US 45000
`define MFC_CF_FULL_HZ 5570
`define MFC_CF_SHIFT_SCF1 7
`define MFC_CF_SHIFT_SCF0 8

`endif

// ===== hw/mfc_pkg.sv
// Types shared by the meter fault and channel select block.
// Assumes the front end delivers filtered magnitudes on the block clock.
package mfc_pkg;

    typedef struct packed {
        logic [15:0] phase_current_input;
        logic [15:0] neutral_current_input;
        logic [15:0] line_voltage_peak;
        logic [15:0] one_wire_gain_trim;
    } mfc_meas_t;

    typedef struct packed {
        logic pulse_scale_select;
        logic rate_select_bit1;
        logic rate_select_bit0;
    } mfc_pins_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } mfc_ahb_in_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } mfc_ahb_out_t;

    typedef struct packed {
        mfc_pins_t pins_s1;
        mfc_pins_t pins_s2;
        mfc_meas_t meas;
        logic ch_neutral;
        logic imbal;
        logic mn;
        logic alarm;
        logic want;
        logic [31:0] swap_cnt;
        logic [31:0] zc_cnt;
        logic [31:0] power;
        logic [55:0] cf_acc;
        logic cf_pulse;
        logic [3:0] status;
        logic [3:0] mask;
        logic det_en;
        logic irq;
        logic dp_wr;
        logic rd_pend;
        logic [11:0] dp_addr;
        mfc_ahb_out_t ahb;
    } mfc_state_t;

endpackage

// ===== verif/mfc_mcu_model.sv
// Controller stand-in: straps the rate pins and counts calibration pulses
// over a timer window, splitting off those counted while the alarm is high.
// Assumes one-cycle pulses on the block clock.
module mfc_mcu_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // from the meter
    input wire logic calibration_pulse_out,
    input wire logic miswire_alarm,
    // from the bench
    input wire logic [2:0] strap_sel,
    input wire logic start,
    input wire logic [31:0] window,
    // results
    output mfc_pkg::mfc_pins_t pins_o,
    output int count,
    output int fault_count,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    import mfc_pkg::*;
    // ************************************************************
    // strap and counter
    // ************************************************************
    logic [31:0] timer_q;
    assign pins_o = mfc_pins_t'(strap_sel);
    assign done = (timer_q == 32'h0);
    // pulses over the window, alarm sampled with each one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_q <= 32'h0;
            count <= 0;
            fault_count <= 0;
        end else if (start) begin
            timer_q <= window;
            count <= 0;
            fault_count <= 0;
        end else if (timer_q != 32'h0) begin
            timer_q <= timer_q - 32'h1;
            count <= count + int'(calibration_pulse_out);
            fault_count <= fault_count + int'(calibration_pulse_out & miswire_alarm);
        end
    end
endmodule

// ===== verif/tb.sv
// Bench for the channel select block: register bus, measurements, pulses.
// Assumes shortened swap and zero crossing counts set at the instance.
`include "mfc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mfc_pkg::*;
    // ************************************************************
    // signals and instances
    // ************************************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic mag_valid = 1'b0;
    logic zero_cross = 1'b0;
    logic zc_en = 1'b0;
    logic start = 1'b0;
    logic [3:0] zc_cnt = 4'h0;
    logic [2:0] strap = 3'h3;
    logic [31:0] window = 32'h0;
    mfc_ahb_in_t bus_q = '0;
    mfc_ahb_in_t ahb_in;
    mfc_ahb_out_t ahb_out;
    mfc_meas_t meas_q = '0;
    mfc_pins_t pins;
    logic alarm, billed_n, mn, cf, irq, done;
    logic [31:0] power;
    int count, fault_count;
    int bad_count = 0;
    int n_tests = 0;
    logic [2:0] s_tab [5] = '{3'h3, 3'h3, 3'h3, 3'h7, 3'h2};
    int t_tab [5] = '{0, 100, 200, 100, 100};
    int sh_tab [5] = '{0, 0, 0, 7, 8};

    always #4 hclk = ~hclk;
    // one slave, so its readyout is the bus ready
    always_comb begin
        ahb_in = bus_q;
        ahb_in.hready = ahb_out.hreadyout;
    end
    // crossings every 16 cycles, well inside the loss window
    always @(posedge hclk) begin
        zc_cnt <= zc_cnt + 4'h1;
        zero_cross <= zc_en && (zc_cnt == 4'h0);
    end

    mfc_channel_select #(.SWAP_CYCLES(32'd20), .ZC_CYCLES(32'd50), .CF_BASE(56'd100000))
        mfc_channel_select_inst (.hclk(hclk), .hresetn(hresetn), .ahb_i(ahb_in),
        .ahb_o(ahb_out), .mag_valid(mag_valid), .meas_i(meas_q), .zero_cross(zero_cross),
        .pins_i(pins), .miswire_alarm(alarm), .billed_is_neutral(billed_n),
        .missing_neutral(mn), .calibration_pulse_out(cf), .billed_power(power), .irq(irq));
    mfc_mcu_model mfc_mcu_model_inst (.hclk(hclk), .hresetn(hresetn),
        .calibration_pulse_out(cf), .miswire_alarm(alarm), .strap_sel(strap), .start(start),
        .window(window), .pins_o(pins), .count(count), .fault_count(fault_count), .done(done));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // start phase of the pulse train is unknown, so allow one either way
    task automatic chk_count(input string nm, input int e, input int g);
        n_tests++;
        if (g < e - 1 || g > e + 1) begin
            bad_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (ahb_out.hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            $display("BAD hready expected 1 seen %b", ahb_out.hreadyout);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        bus_q.hsel <= 1'b1;
        bus_q.haddr <= {20'h00000, a};
        bus_q.htrans <= 2'h2;
        bus_q.hwrite <= w;
        bus_q.hsize <= 3'h2;
        wait_rdy();
        bus_q.hsel <= 1'b0;
        bus_q.htrans <= 2'h0;
        bus_q.hwdata <= wd;
        wait_rdy();
        rd = ahb_out.hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, a, v, d);
    endtask
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk_word(nm, e, d);
    endtask
    task automatic feed(input logic [15:0] p, input logic [15:0] n, input logic [15:0] v,
        input logic [15:0] t);
        meas_q <= '{p, n, v, t};
        mag_valid <= 1'b1;
        @(posedge hclk);
        mag_valid <= 1'b0;
        tick(4);
    endtask
    task automatic run_count(input int i);
        int k;
        strap <= s_tab[i];
        feed(16'h0100, 16'h0100, 16'h1000, 16'(t_tab[i]));
        chk_word("power", 32'(256 * t_tab[i]), power);
        tick(8);
        window <= 32'd2000;
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        tick(2);
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge hclk);
            k++;
        end
        chk_count("pulses", 512000 * t_tab[i] / (100000 << sh_tab[i]), count);
        chk_count("fault pulses", count, fault_count);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
    initial begin
        tick(8);
        hresetn <= 1'b1;
        chk_bit("billed", 1'b0, billed_n);
        rchk("mask", `MFC_OFF_MASK, 32'h0);
        rchk("ctrl", `MFC_OFF_CTRL, 32'h1);
        rchk("unmapped", 12'h010, 32'h0);
        // pulses first: heavy loads later leave a backlog in the accumulator
        for (int i = 0; i < 5; i++) run_count(i);
        $display("test pulses done");
        zc_en <= 1'b1;
        // let a crossing clear the loss flag before leaving missing-neutral
        tick(20);
        feed(16'h0100, 16'h0100, 16'h8000, 16'h0064);
        chk_bit("mn", 1'b0, mn);
        chk_word("power", 32'h0080_0000, power);
        wr(`MFC_OFF_STATUS, 32'hF);
        wr(`MFC_OFF_MASK, 32'h2);
        $display("test reset done");
        feed(16'd1000, 16'd100, 16'h8000, 16'h0064);
        chk_bit("alarm", 1'b1, alarm);
        tick(40);
        chk_bit("billed", 1'b0, billed_n);
        chk_bit("irq", 1'b0, irq);
        feed(16'd100, 16'd1000, 16'h8000, 16'h0064);
        chk_bit("alarm", 1'b1, alarm);
        chk_bit("billed", 1'b0, billed_n);
        tick(30);
        chk_bit("billed", 1'b1, billed_n);
        chk_bit("irq", 1'b1, irq);
        rchk("status", `MFC_OFF_STATUS, 32'h3);
        wr(`MFC_OFF_STATUS, 32'h2);
        tick(2);
        chk_bit("irq", 1'b0, irq);
        $display("test swap done");
        feed(16'd1050, 16'd1000, 16'h8000, 16'h0064);
        chk_bit("alarm", 1'b0, alarm);
        tick(40);
        chk_bit("billed", 1'b1, billed_n);
        feed(16'd2000, 16'd1000, 16'h8000, 16'h0064);
        tick(40);
        chk_bit("billed", 1'b0, billed_n);
        feed(16'h0010, 16'h0050, 16'h8000, 16'h0064);
        chk_bit("alarm", 1'b0, alarm);
        wr(`MFC_OFF_CTRL, 32'h0);
        feed(16'd1000, 16'd100, 16'h8000, 16'h0064);
        chk_bit("alarm", 1'b0, alarm);
        rchk("ctrl", `MFC_OFF_CTRL, 32'h0);
        wr(`MFC_OFF_CTRL, 32'h1);
        $display("test swap back done");
        feed(16'h0100, 16'h0100, 16'h1000, 16'h0064);
        chk_bit("mn", 1'b1, mn);
        chk_bit("alarm", 1'b1, alarm);
        rchk("state", `MFC_OFF_STATE, 32'h5);
        feed(16'h0100, 16'h0100, 16'h170A, 16'h0064);
        chk_bit("mn", 1'b1, mn);
        feed(16'h0100, 16'h0100, 16'h8000, 16'h0064);
        chk_bit("mn", 1'b0, mn);
        zc_en <= 1'b0;
        tick(70);
        chk_bit("mn", 1'b1, mn);
        chk_bit("alarm", 1'b1, alarm);
        zc_en <= 1'b1;
        tick(20);
        chk_bit("mn", 1'b0, mn);
        $display("test missing neutral done");
        give_verdict();
    end
endmodule
